// File: shared/seq_pkg.sv
// Constants and types for the internally clocked output sequencer
package seq_pkg;
   localparam int unsigned REF_CLK_HZ       = 20_000_000;
   localparam int unsigned POR_TIME_US      = 500;
   localparam int unsigned POR_CYCLES       =
      (POR_TIME_US * (REF_CLK_HZ / 1_000_000));
   localparam int unsigned WORD_BITS        = 32;
   localparam int unsigned RESULT_BITS      = 31;
   localparam int unsigned HALF_PERIOD_CYC  = 4;
   localparam int unsigned CONV_CYCLES      = 64;
   localparam logic [4:0]  BIT_CNT_RESET    = 5'h00;
   localparam logic        MODE_INTERNAL    = 1'b1;

   typedef enum logic [2:0] {
      ST_CONVERT = 3'b001,
      ST_SLEEP   = 3'b010,
      ST_OUTPUT  = 3'b100
   } seq_state_t;
endpackage : seq_pkg

// File: rtl/sync3.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output var  logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Output changes only once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            dout <= s3_q;
         end
      end
   end
endmodule // sync3
`default_nettype wire

// File: rtl/por_timer.sv
// Power-on reset timer
`timescale 1ns/1ps
`default_nettype none
module por_timer
   import seq_pkg::*;
#(
   parameter int unsigned POR_CYC = POR_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   output var  logic por_done
);
   logic [15:0] cnt_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q    <= 16'h0000;
         por_done <= 1'b0;
      end else if (!por_done) begin
         cnt_q <= cnt_q + 16'h0001;
         if (cnt_q == 16'(POR_CYC - 1)) begin
            por_done <= 1'b1;
         end
      end
   end
endmodule // por_timer
`default_nettype wire

// File: rtl/out_sequencer.sv
// Convert / sleep / 32-clock output sequencer with internal serial clock
// Functional notes
// - At end of reset, internal clock unless clock pin held low.
// - Reset period ends about 0.5 ms after supply rise; sample then.
// - During conversion in continuous mode, clock and data outputs high.
// - Conversion end drives clock and data low and enters sleep.
// - Sleep at least half a serial clock period, then output unprompted.
// - Output begins at first generated rising edge, ends after 32nd.
// - Data output changes on each falling serial clock edge.
// - Internal modes drive the generated clock onto the clock pin; autostart sleep releases the pin to its pull-up instead.
// - After 32nd rising edge data goes high; clock high throughout.
// - Autostart keeps chip select high by weak pull-up while converting.
// - Autostart sleep discharges chip-select capacitor at constant current.
// - Autostart starts output when chip select drops below threshold.
// - Autostart after 32nd edge pulls chip select high, reconverts.
// - Re-evaluate clock mode at each threshold crossing; keep pull-up.
// - At busy falling edge, load result into the static shift register.
`timescale 1ns/1ps
`default_nettype none
module out_sequencer
   import seq_pkg::*;
#(
   parameter int unsigned POR_CYC = POR_CYCLES
) (
   input  wire logic                   ref_clk,
   input  wire logic                   sys_rst,
   input  wire logic                   link_clk,
   input  wire logic                   sck_in,
   input  wire logic                   cs_low_in,
   input  wire logic                   autostart,
   input  wire logic [RESULT_BITS-1:0] conv_result,
   input  wire logic                   conv_done,
   output logic                        sck_out,
   output logic                        sck_oe,
   output logic                        sck_pullup_en,
   output logic                        sdo_out,
   output logic                        sdo_oe,
   output logic                        cs_pullup_en,
   output logic                        cs_discharge_en,
   output logic                        internal_mode,
   output logic                        por_done,
   output logic                        conv_start
);
   seq_state_t               state_q;
   logic [2:0]               half_q;
   logic                     sck_q;
   logic [5:0]               edge_q;
   logic [WORD_BITS-1:0]     shreg_q;
   logic                     sdo_q;
   logic                     mode_q;
   logic                     por_d1_q;
   logic                     sck_s;
   logic                     cs_low_s;
   logic                     cs_low_prev_q;
   logic                     done_s;
   logic                     done_prev_q;
   logic                     done_pulse;
   logic                     conv_start_q;
   logic                     busy_lk_q;
   logic                     busy_s;
   logic [2:0]               rst_lk_q;
   logic                     link_rst_q;
   logic                     start_lvl_q;
   logic                     start_prev_q;
   logic                     half_end;
   logic                     last_rise;
   logic                     enter_sleep;
   logic                     start_out;
   logic                     end_out;
   logic                     fall_now;
   logic                     rise_now;
   logic                     req_now;

   // Pins come from outside this domain
   sync3 u_sync_sck (
      .clk  (ref_clk),
      .rst  (sys_rst),
      .din  (sck_in),
      .dout (sck_s)
   );

   sync3 u_sync_cs (
      .clk  (ref_clk),
      .rst  (sys_rst),
      .din  (cs_low_in),
      .dout (cs_low_s)
   );

   // Converter core signals completion on its own link clock
   sync3 u_sync_done (
      .clk  (ref_clk),
      .rst  (sys_rst),
      .din  (busy_s),
      .dout (done_s)
   );

   por_timer #(
      .POR_CYC (POR_CYC)
   ) u_por (
      .clk      (ref_clk),
      .rst      (sys_rst),
      .por_done (por_done)
   );

   // Reset reaches the link domain through its own three stages
   always_ff @(posedge link_clk) begin
      rst_lk_q <= {rst_lk_q[1:0], sys_rst};
      if (rst_lk_q[1] == rst_lk_q[2]) begin
         link_rst_q <= rst_lk_q[2];
      end
   end

   // Link-side busy level: set by the start request, cleared by core done
   logic [2:0] start_lk_q;
   always_ff @(posedge link_clk) begin
      if (link_rst_q) begin
         start_lk_q   <= 3'h0;
         start_lvl_q  <= 1'b0;
         start_prev_q <= 1'b0;
         busy_lk_q    <= 1'b0;
      end else begin
         start_lk_q   <= {start_lk_q[1:0], conv_start_q};
         start_prev_q <= start_lvl_q;
         // Request counts only once stages two and three agree
         if (start_lk_q[1] == start_lk_q[2]) begin
            start_lvl_q <= start_lk_q[2];
         end
         if (conv_done) begin
            busy_lk_q <= 1'b0;
         end else if (start_lvl_q && !start_prev_q) begin
            busy_lk_q <= 1'b1;
         end
      end
   end
   assign busy_s = ~busy_lk_q;

   always_ff @(posedge ref_clk) begin
      // Idle level of the synchronised flag is high: no false edge
      if (sys_rst) begin
         done_prev_q <= 1'b1;
      end else begin
         done_prev_q <= done_s;
      end
   end
   assign done_pulse = done_s && !done_prev_q;

   // Clock mode caught on reset release and on threshold crossings
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         por_d1_q      <= 1'b0;
         mode_q        <= MODE_INTERNAL;
         cs_low_prev_q <= 1'b1;
      end else begin
         por_d1_q      <= por_done;
         cs_low_prev_q <= cs_low_s;
         if (por_done && !por_d1_q) begin
            mode_q <= sck_s;
         end else if (autostart && cs_low_s && !cs_low_prev_q) begin
            mode_q <= sck_s;
         end
      end
   end

   // Step decode shared by the per-concern registers below
   assign half_end    = (half_q == 3'(HALF_PERIOD_CYC - 1));
   assign last_rise   = (edge_q == 6'(WORD_BITS)) && sck_q;
   assign enter_sleep = (state_q == ST_CONVERT) && done_pulse;
   assign req_now     = (state_q == ST_CONVERT) && por_d1_q && !conv_start_q
                        && (edge_q == 6'h00);
   // Continuous waits half a period; autostart also waits for threshold
   assign start_out   = (state_q == ST_SLEEP) && half_end
                        && (!autostart || cs_low_s);
   assign end_out     = (state_q == ST_OUTPUT) && half_end && last_rise;
   assign fall_now    = (state_q == ST_OUTPUT) && half_end && !last_rise
                        && sck_q;
   assign rise_now    = (state_q == ST_OUTPUT) && half_end && !sck_q;

   // Main sequencer state
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= ST_CONVERT;
      end else if (enter_sleep) begin
         state_q <= ST_SLEEP;
      end else if (start_out) begin
         state_q <= ST_OUTPUT;
      end else if (end_out) begin
         state_q <= ST_CONVERT;
      end
   end

   // Half-period counter; it parks at its end while sleep waits
   always_ff @(posedge ref_clk) begin
      if (sys_rst || enter_sleep || start_out) begin
         half_q <= 3'h0;
      end else if (state_q == ST_SLEEP && !half_end) begin
         half_q <= half_q + 3'h1;
      end else if (state_q == ST_OUTPUT) begin
         half_q <= half_end ? 3'h0 : half_q + 3'h1;
      end
   end

   // Serial clock: high while converting, low in sleep
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sck_q <= 1'b1;
      end else if (enter_sleep) begin
         sck_q <= 1'b0;
      end else if (state_q == ST_CONVERT) begin
         sck_q <= 1'b1;
      end else if (start_out || rise_now) begin
         sck_q <= 1'b1;
      end else if (fall_now) begin
         sck_q <= 1'b0;
      end
   end

   // Rising edge count; also marks a pending request while converting
   always_ff @(posedge ref_clk) begin
      if (sys_rst || enter_sleep || end_out) begin
         edge_q <= 6'h00;
      end else if (req_now || start_out) begin
         edge_q <= 6'h01;
      end else if (rise_now) begin
         edge_q <= edge_q + 6'h01;
      end
   end

   // Result word, busy bit on top so it leaves on the first rising edge
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         shreg_q <= '0;
      end else if (enter_sleep) begin
         shreg_q <= {1'b0, conv_result};
      end else if (start_out || fall_now) begin
         shreg_q <= {shreg_q[WORD_BITS-2:0], 1'b0};
      end
   end

   // Serial data
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sdo_q <= 1'b1;
      end else if (enter_sleep) begin
         sdo_q <= 1'b0;
      end else if (state_q == ST_CONVERT) begin
         sdo_q <= 1'b1;
      end else if (start_out || fall_now) begin
         sdo_q <= shreg_q[WORD_BITS-1];
      end else if (end_out) begin
         sdo_q <= 1'b1;
      end
   end

   // Conversion request level toward the core
   always_ff @(posedge ref_clk) begin
      if (sys_rst || enter_sleep || end_out) begin
         conv_start_q <= 1'b0;
      end else if (req_now) begin
         conv_start_q <= 1'b1;
      end
   end

   assign internal_mode = mode_q;
   assign sck_out       = sck_q;
   assign sdo_out       = sdo_q;
   assign sdo_oe        = por_d1_q;
   assign conv_start    = conv_start_q;

   // Pin control; the clock pin is let go during an autostart sleep so
   // that the pull-up, not our own low level, decides the next mode
   always_comb begin
      sck_oe          = mode_q && por_d1_q;
      sck_pullup_en   = !por_d1_q;
      cs_pullup_en    = 1'b0;
      cs_discharge_en = 1'b0;
      unique case (state_q)
         ST_CONVERT: begin
            cs_pullup_en = autostart;
         end
         ST_SLEEP: begin
            if (autostart) begin
               sck_oe          = 1'b0;
               sck_pullup_en   = 1'b1;
               cs_discharge_en = 1'b1;
            end
         end
         ST_OUTPUT: begin
            // Recharging here lets the next discharge start from full
            cs_pullup_en = autostart;
         end
      endcase
   end
endmodule // out_sequencer
`default_nettype wire

// File: sim/seq_properties.sv
// Pin-level assertions for the output sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_properties (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic autostart,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic sck_pullup_en,
   input wire logic sdo_out,
   input wire logic cs_pullup_en,
   input wire logic cs_discharge_en,
   input wire logic internal_mode,
   input wire logic por_done
);
   logic [4:0] hi_q;
   logic [5:0] rise_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // A clock held high past one half period marks the convert state
   always_ff @(posedge ref_clk)
      hi_q <= (sys_rst || !sck_out) ? 5'h00 : hi_q + {4'h0, hi_q != 5'h1F};
   always_ff @(posedge ref_clk)
      rise_q <= (sys_rst || hi_q > 5'h05) ? 6'h00
                : rise_q + {5'h00, $rose(sck_out)};
   sequence frame_end;
      sck_out && $past(sck_out) && $rose(sdo_out);
   endsequence
   half_low_a: assert property (
      sck_oe && $fell(sck_out) && !autostart |-> !sck_out [*4] ##1 sck_out)
      else $error("low half length");
   sdo_edge_a: assert property (
      sck_oe && $changed(sdo_out) |-> $fell(sck_out) || sck_out && sdo_out)
      else $error("data edge");
   frame_len_a: assert property (frame_end |-> rise_q == 6'h20)
      else $error("frame length");
   conv_high_a: assert property (
      frame_end |-> (sck_out && sdo_out) [*8]) else $error("convert levels");
   clk_drive_a: assert property (
      por_done && $past(por_done, 2) && !cs_discharge_en
      |-> sck_oe == internal_mode)
      else $error("clock drive");
   cs_pull_a: assert property (
      por_done && autostart && hi_q > 5'h05 && sdo_out
      |-> cs_pullup_en && !cs_discharge_en) else $error("cs pull-up");
   cs_drain_a: assert property (
      autostart && $fell(sck_out) && hi_q > 5'h05 |-> ##[0:1] cs_discharge_en)
      else $error("cs discharge");
   pull_keep_a: assert property (
      cs_discharge_en |-> sck_pullup_en && !sck_oe)
      else $error("clock pull-up");
endmodule // seq_properties
bind out_sequencer seq_properties u_props (.ref_clk, .sys_rst, .autostart,
   .sck_out, .sck_oe, .sck_pullup_en, .sdo_out, .cs_pullup_en,
   .cs_discharge_en, .internal_mode, .por_done);
`default_nettype wire

// File: sim/far_end.sv
// Far side: converter core, chip-select capacitor and result receiver
`timescale 1ns/1ps
`default_nettype none
module far_end (
   input  wire logic        link_clk,
   input  wire logic        ref_clk,
   input  wire logic        conv_start,
   input  wire logic        autostart,
   input  wire logic        cs_pullup_en,
   input  wire logic        cs_discharge_en,
   input  wire logic        sck_out,
   input  wire logic        sdo_out,
   output var  logic        conv_done,
   output wire logic        cs_low_in,
   output var  logic [31:0] rx_word,
   output var  logic [5:0]  rx_cnt
);
   logic [2:0] busy_q = 3'h0;
   logic [6:0] cap_q = 7'h00;
   logic done_tgl = 1'b0;
   logic seen_tgl = 1'b0;
   initial conv_done = 1'b0;
   initial rx_cnt = 6'h00;
   initial rx_word = 32'h0;
   // Conversion ends six link cycles after the request is seen
   always @(posedge link_clk) begin
      busy_q <= !conv_start ? 3'h0 : busy_q + {2'h0, busy_q != 3'h7};
      conv_done <= (busy_q == 3'h6);
      if (busy_q == 3'h6) done_tgl <= !done_tgl;
   end
   // Below threshold after forty cycles; stays low until pulled up again
   always @(posedge ref_clk)
      cap_q <= cs_pullup_en ? 7'h00
               : cap_q + {6'h00, cs_discharge_en && cap_q != 7'h28};
   assign cs_low_in = !autostart || cap_q == 7'h28;
   // Capture on rising clock edges only, busy flag first
   always @(posedge sck_out) begin
      rx_word <= {rx_word[30:0], sdo_out};
      rx_cnt <= (done_tgl != seen_tgl) ? 6'h01 : rx_cnt + 6'h01;
      seen_tgl <= done_tgl;
   end
endmodule // far_end
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the output sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import seq_pkg::*;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ext_low = 1'b0;
   logic autostart = 1'b0;
   logic [RESULT_BITS-1:0] conv_result = 31'h0;
   logic sck_out, sck_oe, sdo_out, conv_done, cs_low_in, conv_start;
   logic cs_dis, cs_pull, mode;
   logic [31:0] rx_word;
   logic [5:0] rx_cnt;
   wire sck_in;
   int n_fail = 0;
   int samples_checked = 0;
   // Top bit selects autostart, the rest is the result to send
   logic [31:0] rows [5] = '{32'h0, 32'h7FFFFFFF, 32'h2AAAAAAA,
      32'hD5555555, 32'h92345678};
   always #25 ref_clk = ~ref_clk;
   always #62.5 link_clk = ~link_clk;
   // Pin reads high through the pull-up unless held low
   assign sck_in = sck_oe ? sck_out : !ext_low;
   out_sequencer #(.POR_CYC(20)) uut (.ref_clk, .link_clk, .sys_rst, .sck_in,
      .cs_low_in, .autostart, .conv_result, .conv_done, .sck_out, .sck_oe,
      .sck_pullup_en(), .sdo_out, .sdo_oe(), .cs_pullup_en(cs_pull),
      .cs_discharge_en(cs_dis), .internal_mode(mode), .por_done(),
      .conv_start);
   far_end partner (.link_clk, .ref_clk, .conv_start, .autostart,
      .cs_pullup_en(cs_pull), .cs_discharge_en(cs_dis), .sck_out, .sdo_out,
      .conv_done, .cs_low_in, .rx_word, .rx_cnt);
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Bounded wait for the edge count to reach or leave 32
   task automatic wait_cnt(input logic want);
      int k;
      for (k = 0; k < 3000 && (rx_cnt == 6'h20) !== want; k++)
         @(negedge ref_clk);
      if (k == 3000) begin
         check("frame wait", 32'(rx_cnt), want ? 32'h20 : 32'h0);
         results();
      end
   endtask
   initial begin
      repeat (7) @(posedge ref_clk);
      @(negedge ref_clk);
      check("reset lines", 32'({sck_oe, sck_out, sdo_out}), 32'h3);
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (28) @(negedge ref_clk);
      check("mode", 32'({mode, sck_oe}), 32'h3);
      $display("test power-on done");
      foreach (rows[i]) begin
         @(posedge ref_clk);
         autostart <= rows[i][31];
         conv_result <= rows[i][30:0];
         wait_cnt(1'b0);
         wait_cnt(1'b1);
         check("word", rx_word, {1'b0, rows[i][30:0]});
         repeat (6) @(negedge ref_clk);
         check("idle lines", 32'({sck_out, sdo_out}), 32'h3);
         check("loop mode", 32'(mode), 32'h1);
         $display("test row %0d done", i);
      end
      // A clock pin held low through power-on picks external clocking
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      ext_low <= 1'b1;
      autostart <= 1'b0;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (28) @(negedge ref_clk);
      check("low pin mode", 32'({mode, sck_oe}), 32'h0);
      $display("test external select done");
      results();
   end
endmodule // tb_top
`default_nettype wire
